// ==== hdl/iosc_ctrl.sv ====
// Contract
// - hf divide code 00 gives core clock hf/8, 01 hf/4, 10 hf/2, 11 hf/1.
// - hf control register reads 11000000 after reset.
// - after any reset the hf oscillator is the core clock source.
// - lf output passes a divider selecting 1, 2, 4 or 8.
// - lf control bits 5:2 fine-tune the lf oscillator frequency.
// - in lf capture mode timer 2 captures on lf falling and timer 3 on rising edges.
// - each capture copies the 16-bit running timer count into its reload pair.
// - lf oscillator runs at a nominal 80 kHz before division and tuning.
`timescale 1ns/1ps
`default_nettype none
`include "iosc_map.svh"
module iosc_ctrl
(
   input wire logic clk,
   input wire logic rst_b,
   input wire iosc_pkg::iosc_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic hf_osc_clk,
   output logic core_clock_en,
   output logic lf_clk_out,
   input wire logic t2_lf_capture_mode,
   input wire logic t3_lf_capture_mode,
   input wire logic [15:0] t2_count,
   input wire logic [15:0] t3_count,
   output iosc_pkg::iosc_cap_s t2_reload,
   output iosc_pkg::iosc_cap_s t3_reload
);
   import iosc_pkg::*;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic hf_osc_enable_q;
   logic [1:0] hf_core_clock_divide_select_q;
   logic lf_osc_enable_q;
   logic [3:0] lf_fine_tune_q;
   logic [1:0] lf_divide_select_q;
   logic hf_freq_ready;
   logic lf_osc_stable;
   logic hf_wr;
   logic lf_wr;

   assign hf_wr = sfr_req.wr && (sfr_req.addr == `IOSC_HF_CTRL_ADDR);
   assign lf_wr = sfr_req.wr && (sfr_req.addr == `IOSC_LF_CTRL_ADDR);

   // hf control: enabled and divide-by-8 from reset, so hf is the clock source
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hf_osc_enable_q <= 1'(`IOSC_HF_CTRL_RST >> `IOSC_EN_BIT);
         hf_core_clock_divide_select_q <= 2'h0;
      end
      else if (hf_wr)
      begin
         hf_osc_enable_q <= sfr_req.wdata[`IOSC_EN_BIT];
         hf_core_clock_divide_select_q <= sfr_req.wdata[`IOSC_DIV_HI:`IOSC_DIV_LO];
      end
   end

   // lf control: tune resets mid-scale as a neutral factory stand-in
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lf_osc_enable_q <= 1'b0;
         lf_fine_tune_q <= `IOSC_LF_TUNE_RST;
         lf_divide_select_q <= 2'h0;
      end
      else if (lf_wr)
      begin
         lf_osc_enable_q <= sfr_req.wdata[`IOSC_EN_BIT];
         lf_fine_tune_q <= sfr_req.wdata[`IOSC_TUNE_HI:`IOSC_TUNE_LO];
         lf_divide_select_q <= sfr_req.wdata[`IOSC_DIV_HI:`IOSC_DIV_LO];
      end
   end

   // ----------------------------------------
   // readback
   // ----------------------------------------
   // read data registered; ready bits are read-only, unused hf bits read zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         sfr_rdata <= 8'h00;
      else if (sfr_req.rd && sfr_req.addr == `IOSC_HF_CTRL_ADDR)
         sfr_rdata <= {hf_osc_enable_q, hf_freq_ready, 4'h0,
                       hf_core_clock_divide_select_q};
      else if (sfr_req.rd && sfr_req.addr == `IOSC_LF_CTRL_ADDR)
         sfr_rdata <= {lf_osc_enable_q, lf_osc_stable, lf_fine_tune_q, lf_divide_select_q};
      else
         sfr_rdata <= 8'h00;
   end

   // ----------------------------------------
   // stability tracking per oscillator
   // ----------------------------------------
   iosc_state_e hf_st_q;
   iosc_state_e lf_st_q;
   logic [7:0] hf_set_q;
   logic [7:0] lf_set_q;

   // hf resets straight to run, since it must be ready out of reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hf_st_q <= IOSC_RUN;
         hf_set_q <= 8'h00;
      end
      else
         case (hf_st_q)
            IOSC_OFF:
            begin
               hf_set_q <= 8'h00;
               if (hf_osc_enable_q)
                  hf_st_q <= IOSC_SETTLE;
            end
            IOSC_SETTLE:
            begin
               hf_set_q <= hf_set_q + 8'h01;
               if (!hf_osc_enable_q)
                  hf_st_q <= IOSC_OFF;
               else if (hf_set_q == `IOSC_HF_SETTLE)
                  hf_st_q <= IOSC_RUN;
            end
            IOSC_RUN:
               if (!hf_osc_enable_q)
                  hf_st_q <= IOSC_OFF;
            default:
               hf_st_q <= IOSC_OFF;
         endcase
   end
   assign hf_freq_ready = (hf_st_q == IOSC_RUN);

   // lf settles for a few of its own half periods; a retune once stable restarts settling
   logic lf_tick;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lf_st_q <= IOSC_OFF;
         lf_set_q <= 8'h00;
      end
      else
         case (lf_st_q)
            IOSC_OFF:
            begin
               lf_set_q <= 8'h00;
               if (lf_osc_enable_q)
                  lf_st_q <= IOSC_SETTLE;
            end
            IOSC_SETTLE:
            begin
               if (lf_tick)
                  lf_set_q <= lf_set_q + 8'h01;
               if (!lf_osc_enable_q)
                  lf_st_q <= IOSC_OFF;
               else if (lf_set_q == `IOSC_LF_SETTLE)
                  lf_st_q <= IOSC_RUN;
            end
            IOSC_RUN:
               if (!lf_osc_enable_q)
                  lf_st_q <= IOSC_OFF;
               else if (lf_wr)
               begin
                  lf_set_q <= 8'h00;
                  lf_st_q <= IOSC_SETTLE;
               end
            default:
               lf_st_q <= IOSC_OFF;
         endcase
   end
   assign lf_osc_stable = (lf_st_q == IOSC_RUN);

   // ----------------------------------------
   // hf post-divider
   // ----------------------------------------
   // hf source is a pin from another domain: two flops before use
   logic hf_s1_q;
   logic hf_s2_q;
   logic hf_s3_q;
   logic [2:0] hf_div_q;
   logic hf_rise;
   logic [2:0] hf_mask;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hf_s1_q <= 1'b0;
         hf_s2_q <= 1'b0;
         hf_s3_q <= 1'b0;
      end
      else
      begin
         hf_s1_q <= hf_osc_clk;
         hf_s2_q <= hf_s1_q;
         hf_s3_q <= hf_s2_q;
      end
   end
   assign hf_rise = hf_s2_q && !hf_s3_q && hf_osc_enable_q;

   // mask picks how many hf edges make one core clock enable
   always_comb
   begin
      case (hf_core_clock_divide_select_q)
         2'h0: hf_mask = 3'h7;
         2'h1: hf_mask = 3'h3;
         2'h2: hf_mask = 3'h1;
         default: hf_mask = 3'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hf_div_q <= 3'h0;
         core_clock_en <= 1'b0;
      end
      else
      begin
         if (hf_rise)
            hf_div_q <= hf_div_q + 3'h1;
         core_clock_en <= hf_rise && ((hf_div_q & hf_mask) == 3'h0);
      end
   end

   // ----------------------------------------
   // lf oscillator model and divider
   // ----------------------------------------
   // tune 0000 fastest, 1111 slowest; step is a coarse digital stand-in for trim
   logic [`IOSC_CNT_W-1:0] lf_cnt_q;
   logic [`IOSC_CNT_W-1:0] lf_half;
   logic lf_raw_q;
   logic [2:0] lf_div_q;
   assign lf_half = `IOSC_CNT_W'(`IOSC_LF_HALF - 8 * `IOSC_TUNE_STEP)
                  + `IOSC_CNT_W'(lf_fine_tune_q) * `IOSC_CNT_W'(`IOSC_TUNE_STEP);
   assign lf_tick = lf_osc_enable_q && (lf_cnt_q >= lf_half - `IOSC_CNT_W'(1));

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lf_cnt_q <= '0;
         lf_raw_q <= 1'b0;
         lf_div_q <= 3'h0;
      end
      else if (!lf_osc_enable_q)
      begin
         lf_cnt_q <= '0;
         lf_raw_q <= 1'b0;
         lf_div_q <= 3'h0;
      end
      else if (lf_tick)
      begin
         lf_cnt_q <= '0;
         lf_raw_q <= !lf_raw_q;
         if (lf_raw_q)
            lf_div_q <= lf_div_q + 3'h1;
      end
      else
         lf_cnt_q <= lf_cnt_q + `IOSC_CNT_W'(1);
   end

   // divided output registered so capture edges see no glitches
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         lf_clk_out <= 1'b0;
      else
         case (lf_divide_select_q)
            2'h0: lf_clk_out <= lf_raw_q;
            2'h1: lf_clk_out <= lf_div_q[0];
            2'h2: lf_clk_out <= lf_div_q[1];
            default: lf_clk_out <= lf_div_q[2];
         endcase
   end

   // ----------------------------------------
   // timer capture of lf edges
   // ----------------------------------------
   // software takes the difference of successive captures to retune
   logic lf_prev_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lf_prev_q <= 1'b0;
         t2_reload <= '0;
         t3_reload <= '0;
      end
      else
      begin
         lf_prev_q <= lf_clk_out;
         t2_reload.capture <= 1'b0;
         t3_reload.capture <= 1'b0;
         if (t2_lf_capture_mode && lf_prev_q && !lf_clk_out)
         begin
            t2_reload.capture <= 1'b1;
            t2_reload.value <= t2_count;
         end
         if (t3_lf_capture_mode && !lf_prev_q && lf_clk_out)
         begin
            t3_reload.capture <= 1'b1;
            t3_reload.value <= t3_count;
         end
      end
   end
endmodule
`default_nettype wire

// ==== hdl/iosc_map.svh ====
`ifndef IOSC_MAP_SVH
`define IOSC_MAP_SVH
// ----------------------------------------
// register addresses and reset values
// ----------------------------------------
`define IOSC_HF_CTRL_ADDR 8'hB2
`define IOSC_LF_CTRL_ADDR 8'hE3
`define IOSC_HF_CTRL_RST 8'hC0
`define IOSC_LF_TUNE_RST 4'h8
// ----------------------------------------
// field positions
// ----------------------------------------
`define IOSC_EN_BIT 7
`define IOSC_RDY_BIT 6
`define IOSC_TUNE_HI 5
`define IOSC_TUNE_LO 2
`define IOSC_DIV_HI 1
`define IOSC_DIV_LO 0
// ----------------------------------------
// timing: lf nominal 80 kHz from 100 MHz core clock
// ----------------------------------------
`define IOSC_CLK_MHZ 100
`define IOSC_LF_KHZ 80
`define IOSC_LF_HALF ((`IOSC_CLK_MHZ * 1000) / (2 * `IOSC_LF_KHZ))
`define IOSC_TUNE_STEP 16
`define IOSC_HF_SETTLE 8'h20
`define IOSC_LF_SETTLE 8'h04
`define IOSC_CNT_W 12
`endif

// ==== hdl/iosc_pkg.sv ====
`default_nettype none
package iosc_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iosc_sfr_req_s;
   typedef struct packed {
      logic capture;
      logic [15:0] value;
   } iosc_cap_s;
   typedef enum logic [2:0] {
      IOSC_OFF = 3'h1,
      IOSC_SETTLE = 3'h2,
      IOSC_RUN = 3'h4
   } iosc_state_e;
endpackage
`default_nettype wire

// ==== verif/iosc_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module iosc_chk
(
   input wire logic clk,
   input wire logic rst_b,
   input wire iosc_pkg::iosc_sfr_req_s sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic hf_osc_clk,
   input wire logic core_clock_en,
   input wire logic lf_clk_out,
   input wire logic t2_lf_capture_mode,
   input wire logic t3_lf_capture_mode,
   input wire logic [15:0] t2_count,
   input wire logic [15:0] t3_count,
   input wire iosc_pkg::iosc_cap_s t2_reload,
   input wire iosc_pkg::iosc_cap_s t3_reload
);
   import iosc_pkg::*;
   logic hw_q;
   logic rb;
   logic [2:0] lfw_q;
   // --------
   // checks
   // --------
   // reset value only holds until the hf register is first written
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         hw_q <= 1'b0;
      else if (sfr_req.wr && sfr_req.addr == 8'hB2)
         hw_q <= 1'b1;
   end
   assign rb = sfr_req.rd && sfr_req.addr == 8'hB2;
   // a divider or enable write may move the output at once; that is no lf edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         lfw_q <= 3'h0;
      else
         lfw_q <= {lfw_q[1:0], sfr_req.wr && sfr_req.addr == 8'hE3};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_hfrst; !hw_q && rb |=> sfr_rdata == 8'hC0; endproperty
   a_hfrst: assert property (p_hfrst) else $error("hf reset value");
   property p_unused; rb |=> sfr_rdata[5:2] == 4'h0; endproperty
   a_unused: assert property (p_unused) else $error("hf unused bits");
   property p_rdy; sfr_req.wr && sfr_req.addr == 8'hB2 && !sfr_req.wdata[7] ##2 rb
      |=> sfr_rdata[7:6] == 2'b00; endproperty
   a_rdy: assert property (p_rdy) else $error("hf ready while off");
   property p_t2; $fell(lf_clk_out) && t2_lf_capture_mode
      |=> t2_reload.capture && t2_reload.value == $past(t2_count); endproperty
   a_t2: assert property (p_t2) else $error("t2 capture");
   property p_t3; $rose(lf_clk_out) && t3_lf_capture_mode
      |=> t3_reload.capture && t3_reload.value == $past(t3_count); endproperty
   a_t3: assert property (p_t3) else $error("t3 capture");
   property p_only; t2_reload.capture
      |-> $past(t2_lf_capture_mode) && !$past(lf_clk_out) && $past(lf_clk_out, 2); endproperty
   a_only: assert property (p_only) else $error("stray t2 capture");
   property p_pulse; core_clock_en |=> !core_clock_en; endproperty
   a_pulse: assert property (p_pulse) else $error("core enable too long");
   property p_lf; $changed(lf_clk_out) |=> ($stable(lf_clk_out) || (|lfw_q)) [*8];
   endproperty
   a_lf: assert property (p_lf) else $error("lf output too fast");
   c_t2: cover property (t2_reload.capture);
   c_t3: cover property (t3_reload.capture);
   c_fast: cover property (core_clock_en ##4 core_clock_en);
endmodule
bind iosc_ctrl iosc_chk u_chk (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .hf_osc_clk(hf_osc_clk), .core_clock_en(core_clock_en),
   .lf_clk_out(lf_clk_out), .t2_lf_capture_mode(t2_lf_capture_mode),
   .t3_lf_capture_mode(t3_lf_capture_mode), .t2_count(t2_count), .t3_count(t3_count),
   .t2_reload(t2_reload), .t3_reload(t3_reload));
`default_nettype wire

// ==== verif/test_internal_oscillator_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_internal_oscillator_control;
   import iosc_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hf = 1'b0;
   logic m2 = 1'b1;
   logic m3 = 1'b1;
   logic [15:0] cnt = 16'h0000;
   iosc_sfr_req_s req = '0;
   logic [7:0] rdata;
   logic [7:0] v;
   logic cen;
   logic lf;
   iosc_cap_s r2;
   iosc_cap_s r3;
   logic [15:0] p [3];
   int n;
   int n3;
   int err_total = 0;
   int samples_checked = 0;
   // hf runs at 25 MHz, toggling on core clock falling edges so syncing is deterministic
   always #5 clk = ~clk;
   always #20 hf = ~hf;
   always @(posedge clk) cnt <= #1 cnt + 16'h0001;
   iosc_ctrl dut (.clk(clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
      .hf_osc_clk(hf), .core_clock_en(cen), .lf_clk_out(lf), .t2_lf_capture_mode(m2),
      .t3_lf_capture_mode(m3), .t2_count(cnt), .t3_count(cnt + 16'h1000),
      .t2_reload(r2), .t3_reload(r3));
   // --------
   // tasks
   // --------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access then an idle cycle, so the strobe is never set twice per step
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      req = '{w, !w, a, d};
      @(posedge clk);
      #1 v = rdata;
      req = '0;
      @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk({8'h00, v}, {8'h00, e});
   endtask
   // s: 0 core enable, 1 t2 capture, 2 t3 capture; n counts cycles waited
   task automatic wt(input int s, output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         #1 c++;
         if (c > 30000)
         begin
            err_total++;
            finish_test();
         end
      end
      while ((s == 0 ? cen : s == 1 ? r2.capture : r3.capture) !== 1'b1);
   endtask
   // first captures after a write are discarded: the output may restart
   task automatic meas(input logic [7:0] ctl, output logic [15:0] per);
      logic [15:0] a;
      logic [15:0] h;
      acc(1'b1, 8'hE3, ctl);
      rdc(8'hE3, ctl);
      wt(2, n);
      wt(2, n);
      a = r3.value;
      wt(1, n);
      h = r2.value + 16'h1000 - a;
      wt(2, n);
      per = r3.value - a;
      chk({h[14:0], 1'b0}, per);
      rdc(8'hE3, ctl | 8'h40);
   endtask
   // --------
   // sequence
   // --------
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      rdc(8'hB2, 8'hC0);
      rdc(8'hE3, 8'h20);
      rdc(8'h00, 8'h00);
      $display("registers done");
      for (int c = 0; c < 4; c++)
      begin
         acc(1'b1, 8'hB2, 8'h80 | 8'(c));
         wt(0, n);
         wt(0, n);
         wt(0, n);
         chk(16'(n), 16'(32 >> c));
         rdc(8'hB2, 8'hC0 | 8'(c));
      end
      acc(1'b1, 8'hB2, 8'h03);
      rdc(8'hB2, 8'h03);
      acc(1'b1, 8'hB2, 8'h87);
      rdc(8'hB2, 8'h83);
      repeat (40) @(posedge clk);
      #1 rdc(8'hB2, 8'hC3);
      $display("hf done");
      meas(8'hA0, p[0]);
      meas(8'hA3, p[1]);
      chk(p[0], 16'd1250);
      chk(p[1], 16'd10000);
      meas(p[0] < p[1] ? 8'hA4 : 8'hA7, p[2]);
      chk(p[2], 16'd1282);
      // t2 capture mode off for one period: t2 stays quiet while t3 still fires once
      m2 = 1'b0;
      n = 0;
      n3 = 0;
      repeat (1400)
      begin
         @(posedge clk);
         #1 n += int'(r2.capture);
         n3 += int'(r3.capture);
      end
      m2 = 1'b1;
      chk(16'(n), 16'h0000);
      chk(16'(n3), 16'h0001);
      $display("lf done");
      finish_test();
   end
endmodule
`default_nettype wire
